// ### common/rtc_pkg.sv
// shared constants and types of the timekeeping core
package rtc_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_TIME_SECONDS            = 7'h00;
  localparam logic [6:0] ADDR_ALARM_SECONDS           = 7'h01;
  localparam logic [6:0] ADDR_TIME_MINUTES            = 7'h02;
  localparam logic [6:0] ADDR_ALARM_MINUTES           = 7'h03;
  localparam logic [6:0] ADDR_TIME_HOURS              = 7'h04;
  localparam logic [6:0] ADDR_ALARM_HOURS             = 7'h05;
  localparam logic [6:0] ADDR_WEEKDAY_COUNT           = 7'h06;
  localparam logic [6:0] ADDR_MONTH_DAY_COUNT         = 7'h07;
  localparam logic [6:0] ADDR_MONTH_COUNT             = 7'h08;
  localparam logic [6:0] ADDR_YEAR_COUNT              = 7'h09;
  localparam logic [6:0] ADDR_RATE_OSCILLATOR_CONTROL = 7'h0A;
  localparam logic [6:0] ADDR_MODE_ENABLE_CONTROL     = 7'h0B;
  localparam logic [6:0] ADDR_INTERRUPT_FLAG_STATUS   = 7'h0C;
  localparam logic [6:0] ADDR_BACKUP_VALID_STATUS     = 7'h0D;

  // ------------------------------------------------------------
  // fields and fixed read values
  // ------------------------------------------------------------
  localparam logic [2:0] OSC_RUN           = 3'h2;
  localparam logic [1:0] OSC_CHAIN_HOLD    = 2'h3;
  localparam logic [1:0] ALARM_ANY         = 2'h3;
  localparam logic [3:0] RS_NONE           = 4'h0;
  localparam logic [3:0] RS_256HZ          = 4'h1;
  localparam logic [3:0] RS_128HZ          = 4'h2;
  localparam logic [3:0] TAP_256HZ         = 4'h6;
  localparam logic [3:0] TAP_128HZ         = 4'h7;
  localparam logic [3:0] TAP_RS_OFFSET     = 4'h2;
  localparam logic [7:0] BACKUP_VALID_READ = 8'h80;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;
  localparam logic [7:0] SECONDS_WR_MASK   = 8'h7F;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CHAIN_W            = 15;
  localparam int OSC_HZ             = 32768;
  localparam int UIP_LEAD_US        = 244;
  localparam int UIP_LEAD_TICKS     = (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
  localparam int FIRST_UPDATE_MS    = 500;
  localparam int FIRST_UPDATE_TICKS = FIRST_UPDATE_MS * OSC_HZ / 1000;
  localparam logic [CHAIN_W-1:0] UPDATE_COUNT    = CHAIN_W'(FIRST_UPDATE_TICKS);
  localparam logic [CHAIN_W-1:0] UIP_START_COUNT =
    CHAIN_W'(FIRST_UPDATE_TICKS - UIP_LEAD_TICKS);

  // ------------------------------------------------------------
  // calendar limits
  // ------------------------------------------------------------
  localparam logic [7:0] TEN             = 8'h0A;
  localparam logic [7:0] SEC_MAX         = 8'h3B;
  localparam logic [7:0] HOUR_MAX        = 8'h17;
  localparam logic [7:0] HOURS_HALF      = 8'h0C;
  localparam logic [7:0] WDAY_MAX        = 8'h07;
  localparam logic [7:0] WDAY_SUNDAY     = 8'h01;
  localparam logic [7:0] MONTH_MAX       = 8'h0C;
  localparam logic [7:0] YEAR_MAX        = 8'h63;
  localparam logic [7:0] MONTH_FEBRUARY  = 8'h02;
  localparam logic [7:0] MONTH_APRIL     = 8'h04;
  localparam logic [7:0] MONTH_OCTOBER   = 8'h0A;
  localparam logic [7:0] FIRST_WEEK_END  = 8'h07;
  localparam logic [7:0] LAST_WEEK_START = 8'h19;
  localparam logic [7:0] DST_PASS_HOUR   = 8'h02;
  localparam logic [7:0] DST_SPRING_HOUR = 8'h03;
  localparam logic [7:0] DST_FALL_HOUR   = 8'h01;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] mday;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } time_t;

  typedef struct packed {
    logic holdUpdates;
    logic periodicIrqEn;
    logic alarmIrqEn;
    logic updateEndIrqEn;
    logic squareOutEn;
    logic binaryFormatSel;
    logic hour24Sel;
    logic summerTimeEn;
  } ctl_t;

  typedef struct packed {
    logic springDay;
    logic fallDay;
    logic fallDone;
  } dst_t;
endpackage

// ### src/rtc_rate_divider.sv
// count-up divider chain, rate tap selection and update timing
`timescale 1ns/1ns
module rtc_rate_divider (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // time base and control
  input  wire logic       oscTick,
  input  wire logic       chainRun,
  input  wire logic [3:0] rateSel,
  // events and levels
  output logic            periodicEvent,
  output logic            updateEvent,
  output logic            uipWindow,
  output logic            tapLevel
);
  typedef struct packed {
    logic [rtc_pkg::CHAIN_W-1:0] count;
    logic                        tapPrev;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  function automatic logic tapOf(input logic [3:0] rs,
                                 input logic [rtc_pkg::CHAIN_W-1:0] c);
    case (rs)
      rtc_pkg::RS_NONE:  return 1'b0;
      rtc_pkg::RS_256HZ: return c[rtc_pkg::TAP_256HZ];
      rtc_pkg::RS_128HZ: return c[rtc_pkg::TAP_128HZ];
      default:           return c[4'(rs - rtc_pkg::TAP_RS_OFFSET)];
    endcase
  endfunction

  // ------------------------------------------------------------
  // chain
  // ------------------------------------------------------------
  always_comb begin
    next_st       = st;
    // stale count must not leak a tap level once the chain stops
    tapLevel      = chainRun && tapOf(rateSel, st.count);
    periodicEvent = chainRun && tapLevel && !st.tapPrev;
    updateEvent   = chainRun && oscTick && (st.count == rtc_pkg::UPDATE_COUNT - 1'b1);
    // update blocked for lead ticks after window opens
    uipWindow     = chainRun && (st.count >= rtc_pkg::UIP_START_COUNT)
                    && (st.count < rtc_pkg::UPDATE_COUNT);
    next_st.tapPrev = tapLevel;
    // chain held at zero unless running
    if (!chainRun) begin
      next_st.count = '0;
    // first update half a chain period after start
    end else if (oscTick) begin
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ### src/rtc_time_step.sv
// one-second advance of the time and calendar bytes
`timescale 1ns/1ns
module rtc_time_step (
  // current state and mode
  input  rtc_pkg::time_t now,
  input  rtc_pkg::dst_t  dstIn,
  input  wire logic      binaryMode,
  input  wire logic      hour24,
  input  wire logic      summerEn,
  // advanced state
  output rtc_pkg::time_t advanced,
  output rtc_pkg::dst_t  dstOut
);
  logic [7:0] s;
  logic [7:0] m;
  logic [7:0] h;
  logic [7:0] v;
  logic [7:0] wd;
  logic [7:0] d;
  logic [7:0] mo;
  logic [7:0] y;

  function automatic logic [7:0] toBin(input logic [7:0] b, input logic bin);
    return bin ? b : ({4'h0, b[7:4]} * rtc_pkg::TEN + {4'h0, b[3:0]});
  endfunction

  function automatic logic [7:0] fromBin(input logic [7:0] b, input logic bin);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = b / rtc_pkg::TEN;
    ones = b % rtc_pkg::TEN;
    return bin ? b : {tens[3:0], ones[3:0]};
  endfunction

  function automatic logic [7:0] daysIn(input logic [7:0] mon, input logic [7:0] yr);
    case (mon)
      rtc_pkg::MONTH_FEBRUARY: return (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: return 8'h1E;
      default: return 8'h1F;
    endcase
  endfunction

  // ------------------------------------------------------------
  // advance
  // ------------------------------------------------------------
  always_comb begin
    s  = toBin(now.sec, binaryMode) + 8'h01;
    m  = toBin(now.min, binaryMode);
    wd = now.wday;
    d  = toBin(now.mday, binaryMode);
    mo = toBin(now.month, binaryMode);
    y  = toBin(now.year, binaryMode);
    v  = toBin({1'b0, now.hour[6:0]}, binaryMode);
    // 12-hour form folded to 0..23 for counting
    if (hour24) begin
      h = toBin(now.hour, binaryMode);
    end else begin
      h = ((v == rtc_pkg::HOURS_HALF) ? 8'h00 : v) + (now.hour[7] ? rtc_pkg::HOURS_HALF : 8'h00);
    end
    dstOut = dstIn;
    if (s > rtc_pkg::SEC_MAX) begin
      s = 8'h00;
      m = m + 8'h01;
    end
    if (m > rtc_pkg::SEC_MAX) begin
      m = 8'h00;
      h = h + 8'h01;
    end
    if (h > rtc_pkg::HOUR_MAX) begin
      h  = 8'h00;
      wd = (wd >= rtc_pkg::WDAY_MAX) ? rtc_pkg::WDAY_SUNDAY : wd + 8'h01;
      d  = d + 8'h01;
      if (d > daysIn(mo, y)) begin
        d  = 8'h01;
        mo = mo + 8'h01;
      end
      if (mo > rtc_pkg::MONTH_MAX) begin
        mo = 8'h01;
        y  = (y >= rtc_pkg::YEAR_MAX) ? 8'h00 : y + 8'h01;
      end
      dstOut.springDay = summerEn && wd == rtc_pkg::WDAY_SUNDAY
                         && mo == rtc_pkg::MONTH_APRIL && d <= rtc_pkg::FIRST_WEEK_END;
      dstOut.fallDay   = summerEn && wd == rtc_pkg::WDAY_SUNDAY
                         && mo == rtc_pkg::MONTH_OCTOBER && d >= rtc_pkg::LAST_WEEK_START;
      dstOut.fallDone  = 1'b0;
    end
    if (h == rtc_pkg::DST_PASS_HOUR && m == 8'h00 && s == 8'h00) begin
      if (dstIn.springDay) begin
        h = rtc_pkg::DST_SPRING_HOUR;
      end else if (dstIn.fallDay && !dstIn.fallDone) begin
        h = rtc_pkg::DST_FALL_HOUR;
        dstOut.fallDone = 1'b1;
      end
    end
    advanced.sec   = fromBin(s, binaryMode);
    advanced.min   = fromBin(m, binaryMode);
    advanced.wday  = wd;
    advanced.mday  = fromBin(d, binaryMode);
    advanced.month = fromBin(mo, binaryMode);
    advanced.year  = fromBin(y, binaryMode);
    v = h % rtc_pkg::HOURS_HALF;
    v = (v == 8'h00) ? rtc_pkg::HOURS_HALF : v;
    v = fromBin(v, binaryMode);
    advanced.hour  = hour24 ? fromBin(h, binaryMode)
                            : {(h >= rtc_pkg::HOURS_HALF), v[6:0]};
  end
endmodule

// ### src/rtc_timekeeping_control.sv
// timekeeping control core: registers, flags, update and rate logic
//
// Function
// - no update within 244 us of UPDATE_PENDING low
// - UPDATE_PENDING read-only, kept through reset
// - hold bit blocks updates, clears UPDATE_PENDING
// - oscillator field: 010 run, 11x hold
// - first update 500 ms after start
// - rate selects tap for square and periodic
// - rate bits read/write, kept through reset
// - time advances once per second unheld
// - periodic flag sets regardless of enable
// - alarm flag on match, 11 matches all
// - update-ended enable cleared by reset/hold
// - square pin follows rate or low
// - data-mode bit picks binary or BCD
// - hour-format bit picks 24 or 12
// - April first Sunday skips 2 AM hour
// - October last Sunday repeats hour once
// - Sunday tests done at midnight, gated
// - binary count ranges of each byte
// - control registers accessible any time
// - summary bit and pin on flag&enable
// - flag read clears, late events kept
// - weekday 1..7, 1 is Sunday
// - update-ended flag set every update
`timescale 1ns/1ns
module rtc_timekeeping_control (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // 32.768 kHz time base pin
  input  wire logic       oscIn,
  // host register port
  input  wire logic [6:0] hostAddr,
  input  wire logic       hostWrite,
  input  wire logic       hostRead,
  input  wire logic [7:0] hostWrData,
  output logic      [7:0] hostRdData,
  // device pins
  output logic            irqN,
  output logic            squareOutPin,
  output logic            oscEnable
);
  typedef struct packed {
    logic [2:0]     oscSync;
    logic           oscLevel;
    rtc_pkg::time_t clock;
    logic [7:0]     alarmSec;
    logic [7:0]     alarmMin;
    logic [7:0]     alarmHour;
    logic           updatePending;
    logic [2:0]     oscCtl;
    logic [3:0]     rateSel;
    rtc_pkg::ctl_t  ctl;
    logic           periodicFlag;
    logic           alarmFlag;
    logic           updateEndFlag;
    logic           requestSummaryFlag;
    rtc_pkg::dst_t  dst;
    logic           squareOut;
    logic [7:0]     rdData;
  } core_state_t;

  core_state_t    st;
  core_state_t    next_st;
  rtc_pkg::time_t advanced;
  rtc_pkg::dst_t  dstAdvanced;
  logic           oscTick;
  logic           chainRun;
  logic           periodicEvent;
  logic           updateEvent;
  logic           uipWindow;
  logic           tapLevel;
  logic           doUpdate;
  logic           alarmHit;
  logic           readFlags;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic alarmMatch(input logic [7:0] a, input logic [7:0] t);
    return (a[7:6] == rtc_pkg::ALARM_ANY) || (a == t);
  endfunction

  function automatic logic [7:0] readReg(input core_state_t s, input logic [6:0] a);
    case (a)
      rtc_pkg::ADDR_TIME_SECONDS:            return s.clock.sec;
      rtc_pkg::ADDR_ALARM_SECONDS:           return s.alarmSec;
      rtc_pkg::ADDR_TIME_MINUTES:            return s.clock.min;
      rtc_pkg::ADDR_ALARM_MINUTES:           return s.alarmMin;
      rtc_pkg::ADDR_TIME_HOURS:              return s.clock.hour;
      rtc_pkg::ADDR_ALARM_HOURS:             return s.alarmHour;
      rtc_pkg::ADDR_WEEKDAY_COUNT:           return s.clock.wday;
      rtc_pkg::ADDR_MONTH_DAY_COUNT:         return s.clock.mday;
      rtc_pkg::ADDR_MONTH_COUNT:             return s.clock.month;
      rtc_pkg::ADDR_YEAR_COUNT:              return s.clock.year;
      rtc_pkg::ADDR_RATE_OSCILLATOR_CONTROL: return {s.updatePending, s.oscCtl, s.rateSel};
      rtc_pkg::ADDR_MODE_ENABLE_CONTROL:     return s.ctl;
      rtc_pkg::ADDR_INTERRUPT_FLAG_STATUS:
        return {s.requestSummaryFlag, s.periodicFlag, s.alarmFlag, s.updateEndFlag, 4'h0};
      rtc_pkg::ADDR_BACKUP_VALID_STATUS:     return rtc_pkg::BACKUP_VALID_READ;
      default:                               return rtc_pkg::UNMAPPED_READ;
    endcase
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  rtc_rate_divider divider (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .oscTick       (oscTick),
    .chainRun      (chainRun),
    .rateSel       (st.rateSel),
    .periodicEvent (periodicEvent),
    .updateEvent   (updateEvent),
    .uipWindow     (uipWindow),
    .tapLevel      (tapLevel)
  );

  rtc_time_step stepper (
    .now        (st.clock),
    .dstIn      (st.dst),
    .binaryMode (st.ctl.binaryFormatSel),
    .hour24     (st.ctl.hour24Sel),
    .summerEn   (st.ctl.summerTimeEn),
    .advanced   (advanced),
    .dstOut     (dstAdvanced)
  );

  // ------------------------------------------------------------
  // oscillator control and time base
  // ------------------------------------------------------------
  // only 010 counts, 11x runs oscillator but holds chain
  assign chainRun  = (st.oscCtl == rtc_pkg::OSC_RUN);
  assign oscEnable = chainRun || (st.oscCtl[2:1] == rtc_pkg::OSC_CHAIN_HOLD);
  // rising pin edge accepted once stages two and three agree
  assign oscTick   = oscEnable && (st.oscSync[1] == st.oscSync[2])
                     && st.oscSync[2] && !st.oscLevel;

  // updates only while hold bit low
  assign doUpdate  = updateEvent && !st.ctl.holdUpdates;
  // don't-care alarm bytes match any time
  assign alarmHit  = alarmMatch(st.alarmSec, advanced.sec)
                     && alarmMatch(st.alarmMin, advanced.min)
                     && alarmMatch(st.alarmHour, advanced.hour);
  assign readFlags = hostRead && (hostAddr == rtc_pkg::ADDR_INTERRUPT_FLAG_STATUS);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.oscSync = {st.oscSync[1:0], oscIn};
    if (st.oscSync[1] == st.oscSync[2]) begin
      next_st.oscLevel = st.oscSync[2];
    end
    if (doUpdate) begin
      next_st.clock = advanced;
      next_st.dst   = dstAdvanced;
    end
    if (hostRead) begin
      next_st.rdData = readReg(st, hostAddr);
    end
    // writes taken in any cycle, after the update
    if (hostWrite) begin
      case (hostAddr)
        rtc_pkg::ADDR_TIME_SECONDS:    next_st.clock.sec = hostWrData & rtc_pkg::SECONDS_WR_MASK;
        rtc_pkg::ADDR_ALARM_SECONDS:   next_st.alarmSec = hostWrData;
        rtc_pkg::ADDR_TIME_MINUTES:    next_st.clock.min = hostWrData;
        rtc_pkg::ADDR_ALARM_MINUTES:   next_st.alarmMin = hostWrData;
        rtc_pkg::ADDR_TIME_HOURS:      next_st.clock.hour = hostWrData;
        rtc_pkg::ADDR_ALARM_HOURS:     next_st.alarmHour = hostWrData;
        rtc_pkg::ADDR_WEEKDAY_COUNT:   next_st.clock.wday = hostWrData;
        rtc_pkg::ADDR_MONTH_DAY_COUNT: next_st.clock.mday = hostWrData;
        rtc_pkg::ADDR_MONTH_COUNT:     next_st.clock.month = hostWrData;
        rtc_pkg::ADDR_YEAR_COUNT:      next_st.clock.year = hostWrData;
        rtc_pkg::ADDR_RATE_OSCILLATOR_CONTROL: begin
          next_st.oscCtl  = hostWrData[6:4];
          next_st.rateSel = hostWrData[3:0];
        end
        // mode bits change only by host write
        rtc_pkg::ADDR_MODE_ENABLE_CONTROL: begin
          next_st.ctl = hostWrData;
          if (hostWrData[7] && !st.ctl.holdUpdates) begin
            next_st.ctl.updateEndIrqEn = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // UPDATE_PENDING high through the lead window only
    next_st.updatePending = uipWindow && !updateEvent && !next_st.ctl.holdUpdates;
    // read clears, events of the same cycle survive
    // periodic flag regardless of its enable
    next_st.periodicFlag  = (st.periodicFlag && !readFlags) || periodicEvent;
    next_st.alarmFlag     = (st.alarmFlag && !readFlags) || (doUpdate && alarmHit);
    // every update sets the update-ended flag
    next_st.updateEndFlag = (st.updateEndFlag && !readFlags) || doUpdate;
    // summary bit from flag and enable pairs
    next_st.requestSummaryFlag =
      (next_st.periodicFlag && next_st.ctl.periodicIrqEn)
      || (next_st.alarmFlag && next_st.ctl.alarmIrqEn)
      || (next_st.updateEndFlag && next_st.ctl.updateEndIrqEn);
    // square pin at tap rate or held low
    next_st.squareOut = next_st.ctl.squareOutEn && tapLevel;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // UPDATE_PENDING, rate, hold and mode bits left alone
      st.oscSync                <= '0;
      st.oscLevel               <= 1'b0;
      st.ctl.periodicIrqEn      <= 1'b0;
      st.ctl.alarmIrqEn         <= 1'b0;
      st.ctl.updateEndIrqEn     <= 1'b0;
      st.ctl.squareOutEn        <= 1'b0;
      st.periodicFlag           <= 1'b0;
      st.alarmFlag              <= 1'b0;
      st.updateEndFlag          <= 1'b0;
      st.requestSummaryFlag     <= 1'b0;
      st.squareOut              <= 1'b0;
      st.rdData                 <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hostRdData   = st.rdData;
  assign irqN         = !st.requestSummaryFlag;
  assign squareOutPin = st.squareOut;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_update;
    updateEvent && !st.ctl.holdUpdates;
  endsequence

  sequence s_flag_read_quiet;
    readFlags && !periodicEvent && !updateEvent;
  endsequence

  a_uip_before_update: assert property (s_update |-> st.updatePending)
    else $error("update taken while UPDATE_PENDING low");
  a_hold_clears_uip: assert property (st.ctl.holdUpdates |-> !st.updatePending)
    else $error("UPDATE_PENDING high while hold set");
  a_hold_freezes_time: assert property (
      st.ctl.holdUpdates && !hostWrite |=> $stable(st.clock))
    else $error("time moved while hold set");
  a_stopped_no_events: assert property (
      st.oscCtl != rtc_pkg::OSC_RUN |-> !updateEvent && !periodicEvent ##1 !st.squareOut)
    else $error("event from stopped chain");
  a_uie_hold_clear: assert property ($rose(st.ctl.holdUpdates) |-> !st.ctl.updateEndIrqEn)
    else $error("update-ended enable survived hold");
  a_periodic_sets_flag: assert property (periodicEvent |=> st.periodicFlag)
    else $error("periodic event lost");
  a_update_sets_flags: assert property (s_update ##1 1 |-> st.updateEndFlag ##0 !st.updatePending)
    else $error("update-ended flag or UPDATE_PENDING wrong after update");
  a_read_clears_flags: assert property (
      s_flag_read_quiet |=> !st.periodicFlag && !st.alarmFlag && !st.updateEndFlag ##0 irqN)
    else $error("flags not cleared by read");
  a_irq_pin_summary: assert property (
      irqN == !((st.periodicFlag && st.ctl.periodicIrqEn) || (st.alarmFlag && st.ctl.alarmIrqEn)
               || (st.updateEndFlag && st.ctl.updateEndIrqEn)))
    else $error("interrupt pin disagrees with flags");
  a_square_low_off: assert property (!st.ctl.squareOutEn |-> !squareOutPin)
    else $error("square pin high while disabled");
endmodule

// ### bench/rtc_host_model.sv
// host bus and time base driver
`timescale 1ns/1ns
module rtc_host_model (
  // clock and time base enable
  input  wire logic       ref_clk,
  input  wire logic       oscOn,
  // host port and time base pin
  output logic      [6:0] hostAddr,
  output logic            hostWrite,
  output logic            hostRead,
  output logic      [7:0] hostWrData,
  input  wire logic [7:0] hostRdData,
  output logic            oscIn
);
  logic [1:0] phase;
  initial begin
    hostAddr = 7'h00;
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostWrData = 8'h00;
    oscIn = 1'b0;
    phase = 2'h0;
  end
  // -----------------------------
  // time base, two cycles a level
  // -----------------------------
  always @(posedge ref_clk) begin
    phase <= phase + 2'h1;
    if (oscOn && phase[0]) begin
      oscIn <= ~oscIn;
    end
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    hostAddr <= a;
    hostWrData <= v;
    hostWrite <= 1'b1;
    @(posedge ref_clk);
    hostWrite <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    hostAddr <= a;
    hostRead <= 1'b1;
    @(posedge ref_clk);
    hostRead <= 1'b0;
    #1 v = hostRdData;
  endtask
endmodule

// ### bench/rtc_timekeeping_control_bench.sv
// self-checking bench of the timekeeping core
`timescale 1ns/1ns
module rtc_timekeeping_control_bench;
  logic       ref_clk, reset_n, oscOn, oscIn, hostWrite, hostRead, irqN, squareOutPin, oscEnable;
  logic [6:0] hostAddr;
  logic [7:0] hostWrData, hostRdData, d;
  int         errorCnt = 0, nTests = 0, cycles = 0, i;
  // rows: address, write data, expected read
  logic [22:0] rows [15] = '{{7'h00, 8'hBB, 8'h3B}, {7'h02, 8'h00, 8'h00},
    {7'h04, 8'h17, 8'h17}, {7'h06, 8'h07, 8'h07}, {7'h07, 8'h1F, 8'h1F}, {7'h08, 8'h0C, 8'h0C},
    {7'h09, 8'h63, 8'h63}, {7'h0B, 8'h86, 8'h86}, {7'h0A, 8'h21, 8'h21},
    {7'h01, 8'hC0, 8'hC0}, {7'h03, 8'hC0, 8'hC0},
    {7'h05, 8'hC0, 8'hC0}, {7'h0D, 8'h00, 8'h80}, {7'h0C, 8'hFF, 8'h00}, {7'h40, 8'h55, 8'h00}};
  rtc_timekeeping_control DUT (.ref_clk(ref_clk), .reset_n(reset_n), .oscIn(oscIn),
    .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .irqN(irqN), .squareOutPin(squareOutPin), .oscEnable(oscEnable));
  rtc_host_model host (.ref_clk(ref_clk), .oscOn(oscOn), .hostAddr(hostAddr),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .oscIn(oscIn));
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errorCnt++;
      report_and_stop();
    end
  end
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    reset_n = 1'b0;
    oscOn = 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    // defined rate first, then one read to drop power-up flags
    host.wr(7'h0A, 8'h21);
    host.rd(7'h0C, d);
    foreach (rows[j]) begin
      host.wr(rows[j][22:16], rows[j][15:8]);
      host.rd(rows[j][22:16], d);
      chkByte(d, rows[j][7:0]);
    end
    chkByte({7'h00, oscEnable}, 8'h01);
    $display("register table done");
    host.wr(7'h0B, 8'h06);
    oscOn <= 1'b1;
    d = 8'h00;
    for (i = 0; i < 40000 && !d[7]; i++) host.rd(7'h0A, d);
    chkByte(d, 8'hA1);
    for (i = 0; i < 100 && d[7]; i++) host.rd(7'h0A, d);
    chkByte(d, 8'h21);
    host.rd(7'h00, d);
    chkByte(d, 8'h00);
    host.rd(7'h02, d);
    chkByte(d, 8'h01);
    host.rd(7'h0C, d);
    chkByte(d, 8'h70);
    $display("first update done");
    host.wr(7'h0B, 8'h46);
    for (i = 0; i < 2000 && irqN !== 1'b0; i++) @(posedge ref_clk);
    chkByte({7'h00, irqN}, 8'h00);
    host.rd(7'h0C, d);
    chkByte(d & 8'hC0, 8'hC0);
    chkByte({7'h00, irqN}, 8'h01);
    host.wr(7'h0B, 8'h16);
    host.wr(7'h0B, 8'h96);
    host.rd(7'h0B, d);
    chkByte(d, 8'h86);
    host.rd(7'h0A, d);
    chkByte(d, 8'h21);
    host.wr(7'h0B, 8'h8E);
    for (i = 0; i < 600 && squareOutPin !== 1'b1; i++) @(negedge ref_clk);
    chkByte({7'h00, squareOutPin}, 8'h01);
    $display("interrupt and hold done");
    reset_n <= 1'b0;
    @(posedge ref_clk);
    #1 chkByte({6'h00, squareOutPin, irqN}, 8'h01);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    host.rd(7'h0B, d);
    chkByte(d, 8'h86);
    host.rd(7'h0A, d);
    chkByte(d, 8'h21);
    $display("reset test done");
    report_and_stop();
  end
endmodule
